/* File: adc_port_pkg.sv */
// =====================================================================
// Shared constants and carriers for the result output port
// =====================================================================
package adc_port_pkg;

    // =================================================================
    // Word and sequence sizes
    // =================================================================
    localparam int RESULT_BITS = 16;   // Width of one conversion result
    localparam int READ_SHIFTS = 16;   // Shift edges per serial read
    localparam int FIFO_WORDS  = 4;    // Result buffer depth

    // =================================================================
    // Shared data bus pin roles
    // =================================================================
    localparam int PIN_DIV_LO   = 2;   // Divider input, low bit
    localparam int PIN_DIV_HI   = 3;   // Divider input, high bit
    localparam int PIN_CLK_SRC  = 4;   // Clock source select
    localparam int PIN_SYNC_POL = 5;   // Frame sync polarity
    localparam int PIN_SCLK_INV = 6;   // Serial clock invert
    localparam int PIN_CHAIN    = 7;   // Read mode or chain input
    localparam int PIN_SERIAL_RESULT_OUT    = 8;   // Serial result out
    localparam int PIN_SCLK     = 9;   // Serial clock in or out
    localparam int PIN_SYNC     = 10;  // Frame sync out
    localparam int PIN_RDERR    = 11;  // Incomplete read flag

    // Driven pins in serial mode: result out, sync and error flag
    localparam logic [15:0] SERIAL_OE_MASK = 16'h0d00;
    localparam logic [15:0] PARALLEL_OE    = 16'hffff;
    localparam logic [15:0] TWOS_MSB_MASK  = 16'h8000;
    localparam logic [15:0] BUS_RESET      = 16'h0000;

    // =================================================================
    // Master serial clock timing
    // =================================================================
    localparam int SYS_CLK_NS       = 4;    // 250 MHz system clock
    localparam int MASTER_SCLK_NS   = 40;   // Undivided serial period
    localparam int MASTER_HALF_CYC  = (MASTER_SCLK_NS / (2 * SYS_CLK_NS)) < 1 ? 1
                                    : MASTER_SCLK_NS / (2 * SYS_CLK_NS);

    // =================================================================
    // Carriers
    // =================================================================
    typedef struct packed {
        logic       serial;      // Serial port selected
        logic       slave;       // External clock selected
        logic       sync_low;    // Frame sync active low
        logic       sclk_inv;    // Serial clock inverted
        logic       rd_during;   // Master reads during conversion
        logic [1:0] div;         // Master clock slow-down
    } mode_s;

    typedef struct packed {
        logic [15:0] data;       // Level driven on each line
        logic [15:0] oe;         // Drive enable per line
    } bus_s;

    // Serial read state
    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } read_state_e;

endpackage : adc_port_pkg

/* File: adc_result_output_port.sv */
`timescale 1ns/100ps
// Function
// - Parallel drives bits 0-1; serial floats them
// - Parallel drives bits 2-3 on lines 2-3
// - Master read-after-convert: lines 2-3 set divider
// - Other serial modes float the divider lines
// - Line 4 picks master or slave clock
// - Slave clock edges ignored without chip select
// - Line 5 low gives active-high frame sync
// - Line 6 inverts serial clock, both modes
// - Chain input appears after sixteen clocks
// - Read mode picks during or after conversion
// - Result shifted MSB first, chosen format
// - Slave updates data on rising, inverted swaps
// - Master frame sync active while data valid
// - Slave read cut by conversion flags error
module adc_result_output_port
    import adc_port_pkg::*;
#(
    parameter int WIDTH       = RESULT_BITS,
    parameter int DEPTH       = FIFO_WORDS,
    parameter int HALF_CYCLES = MASTER_HALF_CYC
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] result_data,
    input  wire logic             result_valid,
    output logic                  result_ready,
    input  wire logic             conv_start,
    input  wire logic             conv_busy,
    input  wire logic             conv_done,
    input  wire logic             serial_parallel_select,
    input  wire logic             binary_twos_select,
    input  wire logic             cs_n,
    input  wire logic [15:0]      d_in,
    output logic      [15:0]      d_out,
    output logic      [15:0]      d_oe
);

    if (WIDTH != READ_SHIFTS)
    begin : g_bad_width
        $error("adc_result_output_port width must equal the shift count");
    end

    // =================================================================
    // Declarations
    // =================================================================
    mode_s            mode;          // Decoded pin roles
    read_state_e      state;         // Serial read state
    logic [WIDTH-1:0] fifo_data;     // Oldest buffered result
    logic             fifo_valid;
    logic             fifo_ready;
    logic             ready_q;       // Buffer ready toward source
    logic [WIDTH-1:0] fmt_word;      // Result in chosen format
    logic [WIDTH-1:0] par_word;      // Word on the parallel bus
    logic [WIDTH-1:0] shift_reg;     // Serial shift register
    logic [3:0]       bit_count;     // Shifts done in this read
    logic             sclk_prev;     // Slave clock, last sample
    logic             sclk_rise;
    logic             sclk_fall;
    logic             slave_upd;     // Gated slave update edge
    logic             master_sclk;   // Master clock, uninverted
    logic             tick;          // Master half-period tick
    logic             shift_edge;    // One shift this cycle
    logic             start;         // Read begins this cycle
    logic             abort;         // Slave read cut short
    logic             rd_err;        // Incomplete read pulse
    bus_s             next_bus;

    // =================================================================
    // Mode decode
    // =================================================================
    // Serial controls sit on the shared data lines
    always_comb
    begin
        mode.serial    = serial_parallel_select;
        mode.slave     = d_in[PIN_CLK_SRC];
        mode.sync_low  = d_in[PIN_SYNC_POL];
        mode.sclk_inv  = d_in[PIN_SCLK_INV];
        mode.rd_during = d_in[PIN_CHAIN];
        // Divider only honoured in master read-after-convert
        if (!d_in[PIN_CLK_SRC] && !d_in[PIN_CHAIN])
        begin
            mode.div = d_in[PIN_DIV_HI:PIN_DIV_LO];
        end
        else
        begin
            mode.div = 2'b00;
        end
    end

    // =================================================================
    // Result buffer
    // =================================================================
    result_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_data   (result_data),
        .in_valid  (result_valid),
        .in_ready  (ready_q),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    assign result_ready = ready_q;

    // Offset binary keeps MSB, twos complement inverts it
    assign fmt_word = binary_twos_select ? fifo_data
                    : fifo_data ^ TWOS_MSB_MASK;

    // =================================================================
    // Read start and buffer drain
    // =================================================================
    always_comb
    begin
        start = 1'b0;
        if (mode.serial && fifo_valid && state == ST_IDLE)
        begin
            if (mode.slave)
            begin
                start = !cs_n;
            end
            else if (mode.rd_during)
            begin
                start = conv_start;
            end
            else
            begin
                start = !conv_busy;
            end
        end
    end

    // Parallel mode drains straight to the bus
    assign fifo_ready = mode.serial ? start : 1'b1;

    // =================================================================
    // Serial clocks
    // =================================================================
    serial_clock_gen #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_clk_gen (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .run     (state == ST_SHIFT && !mode.slave),
        .div     (mode.div),
        .tick    (tick)
    );

    assign sclk_rise = d_in[PIN_SCLK] && !sclk_prev;
    assign sclk_fall = !d_in[PIN_SCLK] && sclk_prev;
    // Update on rising, or on falling when inverted
    assign slave_upd = !cs_n && (mode.sclk_inv ? sclk_fall : sclk_rise);
    // Master updates on each falling half of its own clock
    assign shift_edge = mode.slave ? slave_upd : (tick && master_sclk);
    assign abort = mode.slave && state == ST_SHIFT && conv_done;

    // Slave clock sample for edge detection
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_prev <= 1'b0;
        end
        else
        begin
            sclk_prev <= d_in[PIN_SCLK];
        end
    end

    // Master clock toggles only during a read
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            master_sclk <= 1'b0;
        end
        else if (state != ST_SHIFT || mode.slave)
        begin
            master_sclk <= 1'b0;
        end
        else if (tick)
        begin
            master_sclk <= !master_sclk;
        end
    end

    // =================================================================
    // Serial read sequencer
    // =================================================================
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= ST_IDLE;
            bit_count <= 4'h0;
        end
        else if (!mode.serial || abort)
        begin
            // Parallel select or overrun drops the read
            state     <= ST_IDLE;
            bit_count <= 4'h0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    bit_count <= 4'h0;
                    if (start)
                    begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (shift_edge)
                    begin
                        bit_count <= bit_count + 4'h1;
                        // Last of sixteen shifts ends the read
                        if (bit_count == 4'(READ_SHIFTS - 1))
                        begin
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Shift register, chain bit enters at the bottom
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_reg <= '0;
        end
        else if (start)
        begin
            shift_reg <= fmt_word;
        end
        else if (state == ST_SHIFT && shift_edge && !abort)
        begin
            shift_reg <= {shift_reg[WIDTH-2:0], mode.slave && d_in[PIN_CHAIN]};
        end
    end

    // Parallel word and error pulse
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            par_word <= '0;
            rd_err   <= 1'b0;
        end
        else
        begin
            if (!mode.serial && fifo_valid)
            begin
                par_word <= fmt_word;
            end
            rd_err <= abort;
        end
    end

    // =================================================================
    // Pin drive
    // =================================================================
    always_comb
    begin
        next_bus.data = par_word;
        next_bus.oe   = PARALLEL_OE;
        if (mode.serial)
        begin
            next_bus.data = BUS_RESET;
            next_bus.oe   = SERIAL_OE_MASK;
            next_bus.oe[PIN_SCLK]    = !mode.slave;
            next_bus.data[PIN_SERIAL_RESULT_OUT] = shift_reg[WIDTH-1];
            next_bus.data[PIN_SCLK]  = master_sclk ^ mode.sclk_inv;
            next_bus.data[PIN_SYNC]  = (!mode.slave && state == ST_SHIFT)
                                     ^ mode.sync_low;
            next_bus.data[PIN_RDERR] = rd_err;
        end
    end

    // Registered pins
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            d_out <= BUS_RESET;
            d_oe  <= BUS_RESET;
        end
        else
        begin
            d_out <= next_bus.data;
            d_oe  <= next_bus.oe;
        end
    end

    // =================================================================
    // Assertions
    // =================================================================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_low_bits_float: assert property (
        $past(mode.serial) |-> d_oe[1:0] == 2'b00)
        else $error("low lines driven in serial mode");
    a_mid_bits_drive: assert property (
        $past(reset_n) && !$past(mode.serial) |-> d_oe[3:2] == 2'b11 && d_out[3:2] == $past(par_word[3:2]))
        else $error("parallel bits 2-3 wrong");
    a_div_lines_float: assert property (
        $past(mode.serial) |-> d_oe[PIN_DIV_HI:PIN_DIV_LO] == 2'b00)
        else $error("divider lines driven");
    a_sclk_direction: assert property (
        $past(mode.serial) |-> d_oe[PIN_SCLK] == !$past(mode.slave))
        else $error("serial clock direction wrong");
    a_gated_clock: assert property (
        mode.slave && cs_n && state == ST_SHIFT && !conv_done |=> $stable(shift_reg))
        else $error("shift without chip select");
    a_sync_level: assert property (
        $past(mode.serial && !mode.slave) |->
        d_out[PIN_SYNC] == ($past(state == ST_SHIFT) ^ $past(mode.sync_low)))
        else $error("frame sync level wrong");
    a_sclk_invert: assert property (
        $past(mode.serial) |-> d_out[PIN_SCLK] == ($past(master_sclk) ^ $past(mode.sclk_inv)))
        else $error("serial clock sense wrong");
    a_read_length: assert property (
        state == ST_SHIFT && shift_edge && bit_count == 4'hf && mode.serial |=> state == ST_IDLE)
        else $error("read not ended after sixteen shifts");
    a_after_convert: assert property (
        start && !mode.slave && !mode.rd_during |-> !conv_busy)
        else $error("read started during conversion");
    a_msb_first: assert property (
        start |=> shift_reg == $past(fmt_word) ##1 d_out[PIN_SERIAL_RESULT_OUT] == $past(shift_reg[WIDTH-1]))
        else $error("result not loaded MSB first");
    a_slave_edge: assert property (
        mode.slave && !mode.sclk_inv && state == ST_SHIFT && sclk_fall && !conv_done
        |=> $stable(shift_reg))
        else $error("slave shifted on wrong edge");
    a_read_error: assert property (
        abort |=> rd_err && state == ST_IDLE ##1 !rd_err)
        else $error("incomplete read not flagged");

    c_parallel_word: cover property (!mode.serial && fifo_valid);
    c_master_read:   cover property (state == ST_SHIFT && !mode.slave ##[1:300] state == ST_IDLE);
    c_slave_read:    cover property (start && mode.slave);
    c_read_error:    cover property (abort);

endmodule : adc_result_output_port

/* File: adc_result_output_port_tb.sv */
`timescale 1ns/100ps
// ====================
// Self-checking bench
module adc_result_output_port_tb
    import adc_port_pkg::*;
;
    logic        sys_clk = 1'h0, reset_n = 1'h0;
    logic [15:0] result_data = 16'h0000;
    logic        result_valid = 1'h0, result_ready;
    logic        conv_start = 1'h0, conv_busy = 1'h0, conv_done = 1'h0;
    logic        ser = 1'h0, bin = 1'h1;     // Mode selects
    logic [5:0]  cfg = 6'h00;                // Levels for lines 7:2
    logic [15:0] d_in, d_out, d_oe, pins, w[4], got;
    logic        sclk, cs_n, chain, ch;
    logic [31:0] seed = 32'hb5341574;
    int          fails = 0, samples_checked = 0, bad, n, k;
    realtime     t0;
    // Tester pin levels; wire follows the driver
    assign pins = {6'h00, sclk, 1'h0, cfg[2] ? chain : cfg[5], cfg[4:0], 2'h0};
    assign d_in = (d_oe & d_out) | (~d_oe & pins);
    always #2 sys_clk = ~sys_clk;
    adc_result_output_port #(.HALF_CYCLES(1)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
        .conv_start(conv_start), .conv_busy(conv_busy), .conv_done(conv_done),
        .serial_parallel_select(ser), .binary_twos_select(bin), .cs_n(cs_n),
        .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
    host_model i_host (.sys_clk(sys_clk), .d_out(d_out), .sclk(sclk), .cs_n(cs_n),
        .chain(chain), .hung());
    function automatic logic [15:0] fmt(input logic [15:0] v, input logic b);
        return b ? v : v ^ 16'h8000;
    endfunction : fmt
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // Offer one word and hold it until taken
    task automatic push(input logic [15:0] v);
        int m;
        @(negedge sys_clk);
        result_data = v;
        result_valid = 1'h1;
        for (m = 0; result_ready !== 1'h1 && m < 50; m++) @(negedge sys_clk);
        if (m >= 50)
        begin
            fails++;
            report_and_stop();
        end
        @(negedge sys_clk);
        result_valid = 1'h0;
    endtask : push
    task automatic report_and_stop();
        if (i_host.hung) fails++;
        $display("TB: checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial
    begin
        repeat (2) @(negedge sys_clk);
        reset_n = 1'h1;
        repeat (2) @(negedge sys_clk);
        for (k = 0; k < 6; k++)
        begin
            bin = k[0];
            seed = xs(seed);
            push(seed[15:0]);
            repeat (4) @(negedge sys_clk);
            check(d_out, fmt(seed[15:0], bin));
            check(d_oe, 16'hffff);
        end
        // Slave: fill until refused, then drain
        {ser, bin, cfg} = {2'h2, 6'h04};
        for (k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            w[k] = seed[15:0];
            push(w[k]);
        end
        @(negedge sys_clk);
        check({15'h0000, result_ready}, 16'h0000);
        check(d_oe, 16'h0d00);
        check({14'h0000, d_out[11:10]}, 16'h0000);
        for (k = 0; k < 4; k++)
        begin
            cfg[4] = k[0];
            i_host.rd_slave(k[0], 3 + 2 * k, 16, k[1], got, ch);
            check(got, fmt(w[k], bin));
            check({15'h0000, ch}, {15'h0000, k[1]});
            i_host.drop_cs();
        end
        // Slave read cut by the next conversion
        push(16'h5a5a);
        i_host.rd_slave(cfg[4], 3, 3, 1'h0, got, ch);
        conv_done = 1'h1;
        @(negedge sys_clk);
        conv_done = 1'h0;
        n = 0;
        repeat (6)
        begin
            @(negedge sys_clk);
            n += int'(d_out[11] === 1'h1);
        end
        check(n[15:0], 16'h0001);
        i_host.drop_cs();
        // Master, read during conversion, both sync levels
        for (k = 0; k < 2; k++)
        begin
            cfg = k[0] ? 6'h38 : 6'h20;
            seed = xs(seed);
            push(seed[15:0]);
            @(negedge sys_clk);
            check(d_oe, 16'h0f00);
            check({14'h0000, d_out[10:9]}, {14'h0000, k[0], k[0]});
            conv_start = 1'h1;
            @(negedge sys_clk);
            conv_start = 1'h0;
            i_host.rd_master(k[0], k[0], got, bad);
            check(got, fmt(seed[15:0], bin));
            check(bad[15:0], 16'h0000);
        end
        // Master, read after conversion, divided clock
        cfg = 6'h01;
        conv_busy = 1'h1;
        push(16'h8001);
        repeat (8) @(negedge sys_clk);
        check({15'h0000, d_out[10]}, 16'h0000);
        conv_busy = 1'h0;
        t0 = $realtime;
        i_host.rd_master(1'h0, 1'h0, got, bad);
        check(got, fmt(16'h8001, bin));
        check({15'h0000, ($realtime - t0) >= 240.0}, 16'h0001);
        report_and_stop();
    end
endmodule : adc_result_output_port_tb

/* File: host_model.sv */
`timescale 1ns/100ps
// ====================
// Host end of the serial port
module host_model
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] d_out,
    output logic             sclk,   // Slave clock
    output logic             cs_n,   // Select, low active
    output logic             chain,  // Chain level
    output logic             hung    // Wait ran out
);
    initial
    begin
        {sclk, cs_n, chain, hung} = 4'h4;
    end
    // Slave read: idle level, then update edges
    task automatic rd_slave(input logic inv, input int gap, input int edges, input logic cin,
                            output logic [15:0] w, output logic ch);
        @(negedge sys_clk);
        sclk = inv;
        chain = cin;
        cs_n = 1'h0;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < edges; i++)
        begin
            w[15-i] = d_out[8];
            sclk = ~inv;
            // Chain bit stands one cycle before a held select restarts; gap must be 3 or more
            repeat (2) @(negedge sys_clk);
            ch = d_out[8];
            repeat (gap - 2) @(negedge sys_clk);
            sclk = inv;
            repeat (gap) @(negedge sys_clk);
        end
    endtask : rd_slave
    // Release select; stray edges must be ignored
    task automatic drop_cs();
        @(negedge sys_clk);
        cs_n = 1'h1;
        sclk = ~sclk;
        @(negedge sys_clk);
        sclk = ~sclk;
    endtask : drop_cs
    // Master capture on each rising edge of the uninverted serial clock
    task automatic rd_master(input logic pol, input logic inv, output logic [15:0] w, output int bad);
        int n;
        logic prev;
        n = 0;
        bad = 0;
        while (d_out[10] === pol && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 400) hung = 1'h1;
        prev = d_out[9] ^ inv;
        for (int i = 0; i < 16 && n < 4000; n++)
        begin
            @(negedge sys_clk);
            if (!prev && (d_out[9] ^ inv))
            begin
                w[15-i] = d_out[8];
                bad += int'(d_out[10] === pol);
                i++;
            end
            prev = d_out[9] ^ inv;
        end
        if (n >= 4000) hung = 1'h1;
    endtask : rd_master
endmodule : host_model

/* File: result_fifo.sv */
`timescale 1ns/100ps
// =====================================================================
// Result buffer with registered ready toward the source
// =====================================================================
module result_fifo
    import adc_port_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS,
    parameter int DEPTH = FIFO_WORDS
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // Depth must be a power of two for wrapping pointers
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("result_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];   // Word storage
    logic [PW-1:0]    wr_ptr;        // Next write slot
    logic [PW-1:0]    rd_ptr;        // Oldest word
    logic [CW-1:0]    count;         // Words held
    logic             push;
    logic             pop;
    logic [CW-1:0]    next_count;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Occupancy after this cycle
    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + CW'(1);
        end
        else if (pop && !push)
        begin
            next_count = count - CW'(1);
        end
    end

    // Storage write
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, count and ready flag
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            wr_ptr   <= push ? wr_ptr + PW'(1) : wr_ptr;
            rd_ptr   <= pop ? rd_ptr + PW'(1) : rd_ptr;
            count    <= next_count;
            in_ready <= (next_count < CW'(DEPTH));
        end
    end

endmodule : result_fifo

/* File: serial_clock_gen.sv */
`timescale 1ns/100ps
// =====================================================================
// Half-period tick source for the master serial clock
// =====================================================================
module serial_clock_gen
    import adc_port_pkg::*;
#(
    parameter int HALF_CYCLES = MASTER_HALF_CYC
)
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [1:0] div,
    output logic            tick
);

    if (HALF_CYCLES < 1 || HALF_CYCLES > 31)
    begin : g_bad_half
        $error("serial_clock_gen half period must be 1 to 31 cycles");
    end

    logic [7:0] cnt;     // Cycles in this half period
    logic [7:0] limit;   // Last count, scaled by divider

    assign limit = (8'(HALF_CYCLES) << div) - 8'h01;

    // Counter restarts whenever the clock is stopped
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (cnt >= limit);
            cnt  <= (cnt >= limit) ? 8'h00 : cnt + 8'h01;
        end
    end

endmodule : serial_clock_gen
